/* File: design/adc_regs.vh */
// Contract
// RULE1: Completion loads result, clears start, sets flag
// RULE2: Clock select table depends on reference source
// RULE3: Periods 2/8/32 or RC; internal eight times
// RULE4: Channel select field split, codes 0-5
// RULE5: Thirteen periods; flag rise, start clears fall
// RULE6: Start bit cleared aborts, partial result kept
// RULE7: Power and start together: start cleared
// RULE8: Justify bit selects right or left
// RULE9: Three-bit field selects reference pair
// RULE10: Result not reset; control registers zero
// RULE11: Power bit off stops any conversion
`ifndef ADC_REGS_VH
`define ADC_REGS_VH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define ADC_ADDR_W 12
`define ADC_IDX_W 10
`define ADC_IDX_CONTROL_0 10'h01e
`define ADC_IDX_CONTROL_1 10'h09f
`define ADC_IDX_RESULT_HIGH 10'h0a0
`define ADC_IDX_RESULT_LOW 10'h0a1
`define ADC_IDX_IRQ_STATUS 10'h0a2
`define ADC_IDX_IRQ_MASK 10'h0a3

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ADC_C0_CLKSEL_HI 7
`define ADC_C0_CLKSEL_LO 6
`define ADC_C0_CHAN_HI 5
`define ADC_C0_CHAN_LO 3
`define ADC_C0_START 2
`define ADC_C0_CHAN_B0 1
`define ADC_C0_POWER 0
`define ADC_C1_JUSTIFY 7
`define ADC_C1_REF_HI 6
`define ADC_C1_REF_LO 4
`define ADC_IRQ_DONE 0
`define ADC_CONTROL_0_RESET 8'h00
`define ADC_CONTROL_1_RESET 8'h00
`define ADC_IRQ_RESET 8'h00

// ----------------------------------------------------------------
// Conversion clock periods, in base ticks
// ----------------------------------------------------------------
`define ADC_CNT_W 9
`define ADC_TAD_DIV_00 9'h002
`define ADC_TAD_DIV_01 9'h008
`define ADC_TAD_DIV_10 9'h020
`define ADC_TAD_DIV_RC 9'h002
`define ADC_INT_REF_SHIFT 3
`define ADC_CONV_TADS 4'hd
`define ADC_DONE_TAD 4'he
`define ADC_RESULT_BITS 12

`endif

/* File: design/adc_tad_divider.v */
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.vh"

module adc_tad_divider (
  input wire clock,
  input wire reset_n,
  input wire run,
  input wire [1:0] clock_select,
  input wire internal_ref,
  input wire rc_tick,
  output reg tad_rise,
  output reg tad_fall
);

  reg [`ADC_CNT_W-1:0] count_reg;
  reg [`ADC_CNT_W-1:0] period;
  wire base_tick;

  // RC source counts edges of the RC oscillator, so two per period
  assign base_tick = (clock_select == 2'b11) ? rc_tick : 1'b1;

  always @* begin
    case (clock_select)
      2'b00: period = `ADC_TAD_DIV_00; // RULE3
      2'b01: period = `ADC_TAD_DIV_01; // RULE3
      2'b10: period = `ADC_TAD_DIV_10; // RULE3
      default: period = `ADC_TAD_DIV_RC; // RULE3
    endcase
    if (internal_ref) begin
      period = period << `ADC_INT_REF_SHIFT; // RULE2
    end
  end

  // Restart from zero so the first rise follows the start at once
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= {`ADC_CNT_W{1'b0}};
      tad_rise <= 1'b0;
      tad_fall <= 1'b0;
    end else if (!run) begin
      count_reg <= {`ADC_CNT_W{1'b0}};
      tad_rise <= 1'b0;
      tad_fall <= 1'b0;
    end else begin
      tad_rise <= base_tick && (count_reg == {`ADC_CNT_W{1'b0}});
      tad_fall <= base_tick && (count_reg == (period >> 1));
      if (base_tick) begin
        if (count_reg >= period - 1'b1) begin
          count_reg <= {`ADC_CNT_W{1'b0}};
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: design/adc_control.v */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.vh"

module adc_control #(
  parameter RESULT_WIDTH = `ADC_RESULT_BITS
) (
  input wire clock,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rc_tick,
  input wire comparator_in,
  output reg converter_enable,
  output reg [3:0] channel_select,
  output reg [2:0] reference_config,
  output reg sample_hold,
  output reg [RESULT_WIDTH-1:0] sar_trial,
  output reg conv_busy,
  output reg irq
);

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] adc_control_0_reg;
  reg [7:0] adc_control_0_next;
  reg [7:0] adc_control_1_reg;
  reg [7:0] irq_status_reg;
  reg [7:0] irq_status_next;
  reg [7:0] irq_mask_reg;
  reg [3:0] tad_index_reg;
  reg [3:0] tad_index_next;
  reg [RESULT_WIDTH-1:0] sar_reg;
  reg [RESULT_WIDTH-1:0] sar_next;
  reg [RESULT_WIDTH-1:0] trial_next;
  reg sample_next;
  reg [RESULT_WIDTH-1:0] result_raw_reg;
  reg result_load;
  reg [15:0] result_pair;
  reg [31:0] rdata_next;
  reg decode_hit;
  reg done_event;
  wire tad_rise;
  wire tad_fall;
  wire [`ADC_IDX_W-1:0] reg_index;
  wire access_done;
  wire wr_en;
  wire wr_ctrl0;
  wire wr_ctrl1;
  wire wr_status;
  wire wr_mask;
  wire internal_ref;
  wire start_bit;
  wire power_bit;
  wire [7:0] wbyte;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function uses_internal_ref;
    input [2:0] code;
    begin
      // RULE9
      case (code)
        3'b010, 3'b100, 3'b110, 3'b111: uses_internal_ref = 1'b1;
        default: uses_internal_ref = 1'b0;
      endcase
    end
  endfunction

  function is_index;
    input [`ADC_ADDR_W-1:0] addr;
    input [`ADC_IDX_W-1:0] idx;
    begin
      is_index = (addr[`ADC_ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  assign reg_index = paddr[`ADC_ADDR_W-1:2];
  assign access_done = psel && penable && pready;
  assign wr_en = access_done && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign wr_ctrl0 = wr_en && is_index(paddr, `ADC_IDX_CONTROL_0);
  assign wr_ctrl1 = wr_en && is_index(paddr, `ADC_IDX_CONTROL_1);
  assign wr_status = wr_en && is_index(paddr, `ADC_IDX_IRQ_STATUS);
  assign wr_mask = wr_en && is_index(paddr, `ADC_IDX_IRQ_MASK);
  assign internal_ref = uses_internal_ref(adc_control_1_reg[`ADC_C1_REF_HI:`ADC_C1_REF_LO]); // RULE2
  assign start_bit = adc_control_0_reg[`ADC_C0_START];
  assign power_bit = adc_control_0_reg[`ADC_C0_POWER];

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  adc_tad_divider u_tad_divider (
    .clock(clock),
    .reset_n(reset_n),
    .run(state_reg == ST_CONV),
    .clock_select(adc_control_0_reg[`ADC_C0_CLKSEL_HI:`ADC_C0_CLKSEL_LO]),
    .internal_ref(internal_ref),
    .rc_tick(rc_tick),
    .tad_rise(tad_rise),
    .tad_fall(tad_fall)
  );

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    tad_index_next = tad_index_reg;
    sar_next = sar_reg;
    trial_next = sar_trial;
    sample_next = sample_hold;
    result_load = 1'b0;
    done_event = 1'b0;
    adc_control_0_next = adc_control_0_reg;
    case (state_reg)
      ST_IDLE: begin
        tad_index_next = 4'h0;
        sample_next = 1'b0;
        if (start_bit && power_bit) begin
          state_next = ST_CONV; // RULE5
          sar_next = {RESULT_WIDTH{1'b0}};
          trial_next = {RESULT_WIDTH{1'b0}};
        end
      end
      ST_CONV: begin
        if (!start_bit || !power_bit) begin
          // Abort keeps the partial value already in the result
          state_next = ST_IDLE; // RULE6 RULE11
          sample_next = 1'b0;
          trial_next = {RESULT_WIDTH{1'b0}};
        end else if (tad_rise) begin
          tad_index_next = tad_index_reg + 4'h1;
          if (tad_index_reg == 4'h0) begin
            sample_next = 1'b1;
          end else if (tad_index_next <= `ADC_CONV_TADS) begin
            sample_next = 1'b0;
            trial_next = sar_reg;
            trial_next[RESULT_WIDTH + 1 - tad_index_next] = 1'b1; // RULE5
          end else if (tad_index_next == `ADC_DONE_TAD) begin
            done_event = 1'b1; // RULE1 RULE5
            result_load = 1'b1; // RULE1
            trial_next = {RESULT_WIDTH{1'b0}};
          end
        end else if (tad_fall) begin
          if (tad_index_reg >= 4'h2 && tad_index_reg <= `ADC_CONV_TADS) begin
            sar_next = comparator_in ? sar_trial : sar_reg;
            result_load = 1'b1; // RULE6
          end else if (tad_index_reg == `ADC_DONE_TAD) begin
            state_next = ST_IDLE; // RULE5
            adc_control_0_next[`ADC_C0_START] = 1'b0; // RULE1 RULE5
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // A software write decides the whole register in its cycle
    if (wr_ctrl0) begin
      adc_control_0_next = wbyte;
      if (wbyte[`ADC_C0_POWER] && !power_bit) begin
        adc_control_0_next[`ADC_C0_START] = 1'b0; // RULE7
      end
      if (!wbyte[`ADC_C0_POWER]) begin
        adc_control_0_next[`ADC_C0_START] = 1'b0; // RULE11
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, set wins over write-one-to-clear
  // ----------------------------------------------------------------
  always @* begin
    irq_status_next = irq_status_reg;
    if (wr_status) begin
      irq_status_next = irq_status_reg & ~wbyte;
    end
    if (done_event) begin
      irq_status_next[`ADC_IRQ_DONE] = 1'b1; // RULE1
    end
  end

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  always @* begin
    if (adc_control_1_reg[`ADC_C1_JUSTIFY]) begin
      result_pair = {{(16-RESULT_WIDTH){1'b0}}, result_raw_reg}; // RULE8
    end else begin
      result_pair = {result_raw_reg, {(16-RESULT_WIDTH){1'b0}}}; // RULE8
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = 32'h0000_0000;
    decode_hit = 1'b1;
    case (reg_index)
      `ADC_IDX_CONTROL_0: rdata_next[7:0] = adc_control_0_reg;
      `ADC_IDX_CONTROL_1: rdata_next[7:0] = adc_control_1_reg;
      `ADC_IDX_RESULT_HIGH: rdata_next[7:0] = result_pair[15:8];
      `ADC_IDX_RESULT_LOW: rdata_next[7:0] = result_pair[7:0];
      `ADC_IDX_IRQ_STATUS: rdata_next[7:0] = irq_status_reg;
      `ADC_IDX_IRQ_MASK: rdata_next[7:0] = irq_mask_reg;
      default: decode_hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      decode_hit = 1'b0;
      rdata_next = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Clocked state
  // ----------------------------------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      tad_index_reg <= 4'h0;
      sar_reg <= {RESULT_WIDTH{1'b0}};
      sar_trial <= {RESULT_WIDTH{1'b0}};
      sample_hold <= 1'b0;
      adc_control_0_reg <= `ADC_CONTROL_0_RESET; // RULE10
      adc_control_1_reg <= `ADC_CONTROL_1_RESET; // RULE10
      irq_status_reg <= `ADC_IRQ_RESET;
      irq_mask_reg <= `ADC_IRQ_RESET;
    end else begin
      state_reg <= state_next;
      tad_index_reg <= tad_index_next;
      sar_reg <= sar_next;
      sar_trial <= trial_next;
      sample_hold <= sample_next;
      adc_control_0_reg <= adc_control_0_next;
      if (wr_ctrl1) begin
        adc_control_1_reg <= wbyte;
      end
      irq_status_reg <= irq_status_next;
      if (wr_mask) begin
        irq_mask_reg <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------
  // Read data is captured at setup, so the access cycle sees settled data
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Zero-wait slave: ready in the cycle after setup
      pready <= psel && !penable;
      pslverr <= psel && !penable && !decode_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Built from next values so pins move in the same cycle as the registers;
  // costs a deeper path through the write decode, saves a cycle of skew
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      converter_enable <= 1'b0;
      channel_select <= 4'h0;
      reference_config <= 3'h0;
      conv_busy <= 1'b0;
      irq <= 1'b0;
    end else begin
      converter_enable <= adc_control_0_next[`ADC_C0_POWER]; // RULE11
      // Reserved channel codes pass through; the analog side ignores them
      channel_select <= {adc_control_0_next[`ADC_C0_CHAN_HI:`ADC_C0_CHAN_LO],
                         adc_control_0_next[`ADC_C0_CHAN_B0]}; // RULE4
      reference_config <= wr_ctrl1 ? wbyte[`ADC_C1_REF_HI:`ADC_C1_REF_LO]
                                   : adc_control_1_reg[`ADC_C1_REF_HI:`ADC_C1_REF_LO]; // RULE9
      conv_busy <= (state_next == ST_CONV);
      // Mask written in this cycle already counts
      irq <= |(irq_status_next & (wr_mask ? wbyte : irq_mask_reg));
    end
  end

  // ----------------------------------------------------------------
  // Result storage
  // ----------------------------------------------------------------
  // No reset here: the result survives reset by design
  always @(posedge clock) begin
    if (result_load) begin
      result_raw_reg <= sar_next; // RULE1 RULE10
    end
  end

endmodule
`default_nettype wire

/* File: testbench/adc_control_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.vh"
module adc_control_chk #(parameter RESULT_WIDTH = `ADC_RESULT_BITS) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rc_tick,
  input wire logic comparator_in,
  input wire logic converter_enable,
  input wire logic [3:0] channel_select,
  input wire logic [2:0] reference_config,
  input wire logic sample_hold,
  input wire logic [RESULT_WIDTH-1:0] sar_trial,
  input wire logic conv_busy,
  input wire logic irq
);
  // ----
  // Bus and conversion checks
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  setup_gets_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  read_upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  power_stops_conv_a: assert property (!converter_enable |=> !conv_busy)
    else $error("busy with power off");
  busy_needs_power_a: assert property ($rose(conv_busy) |-> converter_enable)
    else $error("conversion started unpowered");
  settle_no_trial_a: assert property (sample_hold |-> conv_busy && sar_trial == 0)
    else $error("trial during settling");
  first_trial_msb_a: assert property ($fell(sample_hold) && conv_busy |-> sar_trial[RESULT_WIDTH-1])
    else $error("first trial not top bit");
  idle_trial_zero_a: assert property (!conv_busy && !$past(conv_busy) |-> sar_trial == 0)
    else $error("trial word while idle");
  irq_cause_a: assert property ($rose(irq) |-> $past(conv_busy) || $past(pready))
    else $error("interrupt without cause");
  done_c: cover property ($fell(conv_busy));
  irq_c: cover property ($rose(irq));
  err_c: cover property (pslverr);
endmodule
bind adc_control adc_control_chk #(.RESULT_WIDTH(RESULT_WIDTH)) chk (.clock(clock), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rc_tick(rc_tick), .comparator_in(comparator_in),
  .converter_enable(converter_enable), .channel_select(channel_select), .reference_config(reference_config),
  .sample_hold(sample_hold), .sar_trial(sar_trial), .conv_busy(conv_busy), .irq(irq));
`default_nettype wire

/* File: testbench/adc_control_registers_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.vh"
module adc_control_registers_tb_top;
  logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, rc_tick = 0, cmp_in = 0;
  logic [`ADC_ADDR_W-1:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdata;
  logic [3:0] pstrb = 4'hf, channel_select;
  logic pready, pslverr, rerr, converter_enable, sample_hold, conv_busy, irq;
  logic [2:0] reference_config;
  logic [11:0] sar_trial, pr;
  logic [1:0] rcc = 0;
  int error_cnt = 0, checks = 0, n, i;
  localparam [11:0] a_c0 = {`ADC_IDX_CONTROL_0, 2'b00}, a_c1 = {`ADC_IDX_CONTROL_1, 2'b00};
  localparam [11:0] a_rh = {`ADC_IDX_RESULT_HIGH, 2'b00}, a_rl = {`ADC_IDX_RESULT_LOW, 2'b00};
  localparam [11:0] a_st = {`ADC_IDX_IRQ_STATUS, 2'b00}, a_mk = {`ADC_IDX_IRQ_MASK, 2'b00};
  adc_control uut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_tick(rc_tick), .comparator_in(cmp_in), .converter_enable(converter_enable),
    .channel_select(channel_select), .reference_config(reference_config), .sample_hold(sample_hold),
    .sar_trial(sar_trial), .conv_busy(conv_busy), .irq(irq));
  // ----
  // Clock, RC ticks, watchdog
  // ----
  initial forever #4 clock = ~clock;
  // Tick every 4 clocks, so an RC period is 8 clocks
  always @(posedge clock) begin
    rcc <= rcc + 2'd1;
    rc_tick <= (rcc == 2'd3);
  end
  // About 3000 cycles expected; 12500 leaves margin
  initial begin
    #100000;
    error_cnt++;
    end_sim;
  end
  // ----
  // Tasks
  // ----
  task end_sim;
    begin
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    begin
      checks++;
      if (g !== e) begin
        error_cnt++;
        $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Reads see pready before this edge's updates land
  task xf(input w, input [11:0] a, input [31:0] d);
    int t;
    begin
      t = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
        @(posedge clock);
        t++;
      end while (pready !== 1'b1 && t < 50);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the write's register updates settle before any compare
      @(negedge clock);
    end
  endtask
  task rd_chk(input [11:0] a, input [31:0] e);
    begin
      xf(1'b0, a, 32'h0);
      cmp(rdata, e);
    end
  endtask
  task conv(input [1:0] cs, input [2:0] rf, input j, input c, input int p);
    logic [15:0] e;
    begin
      e = j ? {4'h0, {12{c}}} : {{12{c}}, 4'h0};
      cmp_in <= c;
      xf(1'b1, a_c1, {24'h0, j, rf, 4'h0});
      xf(1'b1, a_c0, {24'h0, cs, 6'h01});
      xf(1'b1, a_c0, {24'h0, cs, 6'h05});
      n = 0;
      repeat (2) @(posedge clock);
      while (conv_busy === 1'b1 && n < 5000) begin
        n++;
        @(posedge clock);
      end
      cmp(n >= 13 * p && n <= 14 * p + 8, 1);
      cmp(irq, 1);
      rd_chk(a_c0, {cs, 6'h01});
      rd_chk(a_st, 1);
      rd_chk(a_rh, e[15:8]);
      rd_chk(a_rl, e[7:0]);
      xf(1'b1, a_st, 32'h1);
      repeat (2) @(posedge clock);
      cmp(irq, 0);
    end
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    rd_chk(a_c0, 0);
    rd_chk(a_c1, 0);
    rd_chk(a_st, 0);
    rd_chk(a_mk, 0);
    for (i = 0; i < 16; i++) begin
      xf(1'b1, a_c0, {26'h0, i[3:1], 1'b0, i[0], 1'b0});
      cmp(channel_select, i[3:0]);
    end
    for (i = 0; i < 8; i++) begin
      xf(1'b1, a_c1, {24'h0, 1'b1, i[2:0], 4'ha});
      cmp(reference_config, i[2:0]);
      rd_chk(a_c1, {1'b1, i[2:0], 4'ha});
    end
    // Strobe off: write must be dropped
    pstrb <= 4'h0;
    xf(1'b1, a_c1, 32'h0);
    pstrb <= 4'hf;
    rd_chk(a_c1, 8'hfa);
    xf(1'b0, 12'h100, 32'h0);
    cmp(rerr, 1);
    cmp(rdata, 0);
    xf(1'b1, a_c0, 8'h04);
    rd_chk(a_c0, 8'h00);
    xf(1'b1, a_c0, 8'h05);
    rd_chk(a_c0, 8'h01);
    cmp(conv_busy, 0);
    xf(1'b1, a_mk, 32'h1);
    cmp(irq, 0);
    conv(2'b00, 3'b000, 1'b1, 1'b1, 2);
    conv(2'b01, 3'b001, 1'b0, 1'b1, 8);
    conv(2'b10, 3'b011, 1'b1, 1'b1, 32);
    conv(2'b00, 3'b010, 1'b0, 1'b1, 16);
    conv(2'b11, 3'b101, 1'b1, 1'b1, 8);
    conv(2'b01, 3'b111, 1'b0, 1'b0, 64);
    conv(2'b00, 3'b100, 1'b1, 1'b0, 16);
    conv(2'b00, 3'b110, 1'b1, 1'b1, 16);
    // Abort about seven trials in
    cmp_in <= 1'b1;
    xf(1'b1, a_c1, 32'h80);
    xf(1'b1, a_c0, 32'h45);
    repeat (60) @(posedge clock);
    xf(1'b1, a_c0, 32'h41);
    repeat (2) @(posedge clock);
    cmp(conv_busy, 0);
    xf(1'b0, a_rh, 32'h0);
    pr[11:8] = rdata[3:0];
    xf(1'b0, a_rl, 32'h0);
    pr[7:0] = rdata[7:0];
    cmp(pr[11] & (pr != 12'hfff), 1);
    rd_chk(a_st, 0);
    rd_chk(a_c0, 8'h41);
    end_sim;
  end
endmodule
`default_nettype wire
